//--- rtl/rxezo_irq.sv
// Excessive-zero change and oversize-message interrupt group with AXI4-Lite register slave
//
// Behaviour
// [R1] Set zero-run change flag when excessive-zero detection begins.
// [R2] Also set zero-run change flag when excessive-zero detection ends.
// [R3] Zero-run change flag in bit 0, resets to 0, clears on register read.
// [R4] Flag 1 means event since previous read; 0 means none since then; a summary clear write with bit 0 set also zeroes the flag.
// [R5] Zero-run enable bit 0, reset 0, permits interrupt when 1, suppresses when 0.
// [R6] Raise oversize-message event when a controller 1 message exceeds 276 bytes.
// [R7] Oversize flag in bit 0, resets to 0, cleared by reading its register.
// [R8] Oversize enable: 0 disables, 1 enables interrupt; bit is read and write.
// [R9] Interrupt high while any flag set with matching enable; drops once cleared.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps

module rxezo_irq
    import rxezo_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         zero_run_detect,
    input  wire logic                         msg_byte_strobe,
    input  wire logic                         msg_end_strobe,
    output logic                              irq,
    input  wire logic [rxezo_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [rxezo_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [rxezo_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [rxezo_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    import rxezo_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decoding shared by both channels

    function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[IDX_W+1:2];
    endfunction : reg_index

    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
        hits = (addr[1:0] == 2'h0) && (reg_index(addr) == idx);
    endfunction : hits

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        mapped = hits(addr, EZ_STATUS_IDX) || hits(addr, EZ_ENABLE_IDX)
              || hits(addr, LM_STATUS_IDX) || hits(addr, LM_ENABLE_IDX)
              || hits(addr, SUM_STATUS_IDX) || hits(addr, SUM_CLEAR_IDX)
              || hits(addr, SUM_ENABLE_IDX);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic                  zero_run_change_flag_reg;
    logic                  zero_run_change_flag_next;
    logic                  zero_run_change_irq_en_reg;
    logic                  zero_run_change_irq_en_next;
    logic                  long_msg_flag_ctl1_reg;
    logic                  long_msg_flag_ctl1_next;
    logic                  long_msg_irq_en_ctl1_reg;
    logic                  long_msg_irq_en_ctl1_next;
    logic                  zero_run_prev_reg;
    logic [MSG_CNT_W-1:0]  msg_cnt_reg;
    logic [MSG_CNT_W-1:0]  msg_cnt_next;

    // Write halves wait here until both have arrived
    logic                  aw_held_reg;
    logic [ADDR_W-1:0]     aw_addr_reg;
    logic                  w_held_reg;
    logic [DATA_W-1:0]     w_data_reg;
    logic                  w_lane0_reg;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic                  rvalid_reg;
    logic [DATA_W-1:0]     rdata_reg;
    logic [1:0]            rresp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshakes

    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire ar_take  = s_axi_arvalid && s_axi_arready;
    wire wr_fire  = aw_held_reg && w_held_reg;

    // Readies stay low while a response waits, so one write at most is in flight
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Writes only act on byte lane 0 since every register is eight bits wide
    wire wr_ok       = wr_fire && w_lane0_reg;
    wire wr_ez_en    = wr_ok && hits(aw_addr_reg, EZ_ENABLE_IDX);
    wire wr_lm_en    = wr_ok && hits(aw_addr_reg, LM_ENABLE_IDX);
    wire wr_sum_en   = wr_ok && hits(aw_addr_reg, SUM_ENABLE_IDX);
    wire wr_sum_clr  = wr_ok && hits(aw_addr_reg, SUM_CLEAR_IDX);
    wire wr_mapped   = mapped(aw_addr_reg);

    // Read address decode, shared by the clear strobes and the data mux
    wire rd_hit_ez_st  = hits(s_axi_araddr, EZ_STATUS_IDX);
    wire rd_hit_ez_en  = hits(s_axi_araddr, EZ_ENABLE_IDX);
    wire rd_hit_lm_st  = hits(s_axi_araddr, LM_STATUS_IDX);
    wire rd_hit_lm_en  = hits(s_axi_araddr, LM_ENABLE_IDX);
    wire rd_hit_sum_st = hits(s_axi_araddr, SUM_STATUS_IDX);
    wire rd_hit_sum_en = hits(s_axi_araddr, SUM_ENABLE_IDX);

    // [R3] read clears flag
    wire rd_ez_clr   = ar_take && rd_hit_ez_st;
    // [R7] read clears flag
    wire rd_lm_clr   = ar_take && rd_hit_lm_st;

    wire clr_ez      = rd_ez_clr || (wr_sum_clr && w_data_reg[SUM_ZERO_RUN_BIT]);
    wire clr_lm      = rd_lm_clr || (wr_sum_clr && w_data_reg[SUM_LONG_MSG_BIT]);

    ////////////////////////////////////////////////////////////////////////////////
    // Event detection

    // [R1] [R2] either edge of detection
    wire zero_run_event = zero_run_detect ^ zero_run_prev_reg;

    // [R6] fires on byte 277 only
    wire long_msg_event = msg_byte_strobe && (msg_cnt_reg == MSG_MAX_CNT);

    // Counter saturates so a very long message raises a single event
    always_comb
    begin
        msg_cnt_next = msg_cnt_reg;
        if (msg_end_strobe)
        begin
            msg_cnt_next = '0;
        end
        else if (msg_byte_strobe && (msg_cnt_reg != MSG_SAT_CNT))
        begin
            msg_cnt_next = msg_cnt_reg + MSG_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flag and enable next state

    // [R4] set beats a same-cycle clear so no event is lost
    assign zero_run_change_flag_next = (zero_run_change_flag_reg && !clr_ez) || zero_run_event;
    assign long_msg_flag_ctl1_next   = (long_msg_flag_ctl1_reg && !clr_lm) || long_msg_event;

    // [R5] enable bit written by software
    assign zero_run_change_irq_en_next = wr_ez_en  ? w_data_reg[ZERO_RUN_BIT] :
                                         wr_sum_en ? w_data_reg[SUM_ZERO_RUN_BIT] :
                                                     zero_run_change_irq_en_reg;
    // [R8] enable bit written by software
    assign long_msg_irq_en_ctl1_next   = wr_lm_en  ? w_data_reg[LONG_MSG_BIT] :
                                         wr_sum_en ? w_data_reg[SUM_LONG_MSG_BIT] :
                                                     long_msg_irq_en_ctl1_reg;

    // [R9] level output, gated by enables
    assign irq = (zero_run_change_flag_reg && zero_run_change_irq_en_reg)
              || (long_msg_flag_ctl1_reg && long_msg_irq_en_ctl1_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data selection

    wire [REG_W-1:0] ez_status_val  = REG_W'(zero_run_change_flag_reg)   << ZERO_RUN_BIT;
    wire [REG_W-1:0] ez_enable_val  = REG_W'(zero_run_change_irq_en_reg) << ZERO_RUN_BIT;
    wire [REG_W-1:0] lm_status_val  = REG_W'(long_msg_flag_ctl1_reg)     << LONG_MSG_BIT;
    wire [REG_W-1:0] lm_enable_val  = REG_W'(long_msg_irq_en_ctl1_reg)   << LONG_MSG_BIT;
    wire [REG_W-1:0] sum_status_val = (REG_W'(zero_run_change_flag_reg) << SUM_ZERO_RUN_BIT)
                                    | (REG_W'(long_msg_flag_ctl1_reg)   << SUM_LONG_MSG_BIT);
    wire [REG_W-1:0] sum_enable_val = (REG_W'(zero_run_change_irq_en_reg) << SUM_ZERO_RUN_BIT)
                                    | (REG_W'(long_msg_irq_en_ctl1_reg)   << SUM_LONG_MSG_BIT);

    // Clear register is write-only and reads as zero
    wire [REG_W-1:0] rd_val = rd_hit_ez_st  ? ez_status_val  :
                              rd_hit_ez_en  ? ez_enable_val  :
                              rd_hit_lm_st  ? lm_status_val  :
                              rd_hit_lm_en  ? lm_enable_val  :
                              rd_hit_sum_st ? sum_status_val :
                              rd_hit_sum_en ? sum_enable_val :
                                              '0;
    // Unaligned or unmapped reads get a decode error and zero data
    wire [1:0] rd_resp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt group registers

    // Status flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            zero_run_change_flag_reg <= EZ_STATUS_RST[ZERO_RUN_BIT];
            long_msg_flag_ctl1_reg   <= LM_STATUS_RST[LONG_MSG_BIT];
        end
        else
        begin
            zero_run_change_flag_reg <= zero_run_change_flag_next;
            long_msg_flag_ctl1_reg   <= long_msg_flag_ctl1_next;
        end
    end

    // Enable bits
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            zero_run_change_irq_en_reg <= EZ_ENABLE_RST[ZERO_RUN_BIT];
            long_msg_irq_en_ctl1_reg   <= LM_ENABLE_RST[LONG_MSG_BIT];
        end
        else
        begin
            zero_run_change_irq_en_reg <= zero_run_change_irq_en_next;
            long_msg_irq_en_ctl1_reg   <= long_msg_irq_en_ctl1_next;
        end
    end

    // Detector history resets to the idle level, so no false edge follows reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            zero_run_prev_reg <= 1'b0;
            msg_cnt_reg       <= '0;
        end
        else
        begin
            zero_run_prev_reg <= zero_run_detect;
            msg_cnt_reg       <= msg_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, response after both

    // Address half
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (aw_take)
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            aw_held_reg <= 1'b0;
        end
    end

    // Data half
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            w_held_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_lane0_reg <= 1'b0;
        end
        else if (w_take)
        begin
            w_held_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata;
            w_lane0_reg <= s_axi_wstrb[0];
        end
        else if (wr_fire)
        begin
            w_held_reg <= 1'b0;
        end
    end

    // Response; a bready with nothing pending leaves bvalid low anyway
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel: data captured at the address handshake, when the flag clears

    // Read valid
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rvalid_reg <= 1'b0;
        end
        else if (ar_take)
        begin
            rvalid_reg <= 1'b1;
        end
        else if (s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    // Read data and response, held until the next address is taken
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rdata_reg <= DATA_W'(rd_val);
            rresp_reg <= rd_resp;
        end
    end

endmodule : rxezo_irq

//--- rtl/rxezo_pkg.sv
// Register map, field layout, reset values and limits of the receive interrupt group
package rxezo_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned REG_W     = 8;
    localparam int unsigned IDX_W     = 14;

    // Register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] EZ_STATUS_IDX  = 14'h0B0E;
    localparam logic [IDX_W-1:0] EZ_ENABLE_IDX  = 14'h0B0F;
    localparam logic [IDX_W-1:0] LM_STATUS_IDX  = 14'h0B10;
    localparam logic [IDX_W-1:0] LM_ENABLE_IDX  = 14'h0B11;
    localparam logic [IDX_W-1:0] SUM_STATUS_IDX = 14'h0B20;
    localparam logic [IDX_W-1:0] SUM_CLEAR_IDX  = 14'h0B21;
    localparam logic [IDX_W-1:0] SUM_ENABLE_IDX = 14'h0B22;

    // Field positions in the documented registers
    localparam int unsigned ZERO_RUN_BIT = 0;
    localparam int unsigned LONG_MSG_BIT = 0;

    // Field positions in the summary status, clear and enable registers
    localparam int unsigned SUM_ZERO_RUN_BIT = 0;
    localparam int unsigned SUM_LONG_MSG_BIT = 1;

    // Reset values
    localparam logic [REG_W-1:0] EZ_STATUS_RST = 8'h00;
    localparam logic [REG_W-1:0] EZ_ENABLE_RST = 8'h00;
    localparam logic [REG_W-1:0] LM_STATUS_RST = 8'h00;
    localparam logic [REG_W-1:0] LM_ENABLE_RST = 8'h00;

    // Longest legal received message in bytes
    localparam int unsigned     MSG_MAX_BYTES = 276;
    localparam int unsigned     MSG_CNT_W     = 9;
    localparam logic [MSG_CNT_W-1:0] MSG_MAX_CNT = MSG_CNT_W'(MSG_MAX_BYTES);
    localparam logic [MSG_CNT_W-1:0] MSG_SAT_CNT = MSG_CNT_W'(MSG_MAX_BYTES + 1);

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : rxezo_pkg

//--- testbench/rxezo_irq_assertions.sv
// Port-level assertions for the receive interrupt group
`timescale 1ns/100ps
module rxezo_irq_assertions
    import rxezo_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        zero_run_detect,
    input wire logic        msg_byte_strobe,
    input wire logic        irq,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [15:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_resp_late;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_write_answer: assert property (s_both_taken |=> s_resp_late)
        else $error("write response not two cycles after request");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after request");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("reserved read bits not zero");
    a_unmapped_decerr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[15:8] != 8'h2C
        |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    // A rise needs an edge of the detector, a byte, a register write or a fresh reset
    a_irq_rise_cause: assert property ($rose(irq) |->
        $past(zero_run_detect) != $past(zero_run_detect, 2) || $past(msg_byte_strobe)
        || $rose(s_axi_bvalid) || $past(rst, 2))
        else $error("interrupt rose without cause");
    a_irq_fall_cause: assert property ($fell(irq) |->
        ($past(s_axi_arvalid) && $past(s_axi_arready)) || $rose(s_axi_bvalid))
        else $error("interrupt fell without read or write");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
endmodule : rxezo_irq_assertions

bind rxezo_irq rxezo_irq_assertions u_rxezo_chk (.clk, .rst, .zero_run_detect, .msg_byte_strobe, .irq,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

//--- testbench/rxezo_irq_tb.sv
// Self-checking bench for the receive interrupt group
`timescale 1ns/100ps
module rxezo_irq_tb;
    import rxezo_pkg::*;
    localparam logic [15:0] SUM_ST = {SUM_STATUS_IDX, 2'b00};
    localparam logic [15:0] SUM_CL = {SUM_CLEAR_IDX, 2'b00};
    localparam logic [15:0] SUM_EN = {SUM_ENABLE_IDX, 2'b00};
    localparam logic [15:0] EZ_ST = {EZ_STATUS_IDX, 2'b00};
    localparam logic [15:0] EZ_EN = {EZ_ENABLE_IDX, 2'b00};
    localparam logic [15:0] LM_ST = {LM_STATUS_IDX, 2'b00};
    localparam logic [15:0] LM_EN = {LM_ENABLE_IDX, 2'b00};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        zero_run_detect = 1'b0;
    logic        msg_byte_strobe = 1'b0;
    logic        msg_end_strobe = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000;
    logic [15:0] s_axi_araddr = 16'h0000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    int          err_total = 0;
    int          n_checks = 0;

    always #5 clk = ~clk;

    rxezo_irq dut (.clk, .rst, .zero_run_detect, .msg_byte_strobe, .msg_end_strobe, .irq, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic time_out;
        err_total++;
        complete_run();
    endtask : time_out

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    // Irq is combinational from registers, so let the edge settle first
    task automatic chk_bit(input string what, input logic exp);
        #1;
        chk_word(what, {31'h0, exp}, {31'h0, irq});
    endtask : chk_bit

    ////////////////////////////////////////////////////////////////////////////////
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        bit ad = 1'b0;
        bit wd = 1'b0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid  <= !wd;
        end
        while (!(ad && wd) && ++n < 50);
        do @(posedge clk); while (!s_axi_bvalid && ++n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 50) time_out();
    endtask : axi_write

    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk); while (!s_axi_arready && ++n < 50);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid && ++n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 50) time_out();
    endtask : axi_read

    task automatic set_detect(input logic v);
        @(posedge clk);
        zero_run_detect <= v;
        repeat (2) @(posedge clk);
    endtask : set_detect

    // Bytes arrive back to back, the closing strobe in a cycle of its own
    task automatic send_msg(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            msg_byte_strobe <= 1'b1;
        end
        @(posedge clk);
        msg_byte_strobe <= 1'b0;
        msg_end_strobe  <= 1'b1;
        @(posedge clk);
        msg_end_strobe <= 1'b0;
    endtask : send_msg

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        logic [15:0] regs [4] = '{EZ_ST, EZ_EN, LM_ST, LM_EN};
        foreach (regs[i])
        begin
            axi_read(regs[i], rd, rs);
            chk_word("reset value", 32'h00000000, rd);
        end
    endtask : t_reset_values

    task automatic t_zero_run;
        axi_write(EZ_EN, 32'h000000FF, rs);
        axi_read(EZ_EN, rd, rs);
        chk_word("zero-run enable", 32'h00000001, rd);
        set_detect(1'b1);
        chk_bit("irq on detect", 1'b1);
        axi_read(EZ_ST, rd, rs);
        chk_word("zero-run flag", 32'h00000001, rd);
        axi_read(EZ_ST, rd, rs);
        chk_word("flag after read", 32'h00000000, rd);
        chk_bit("irq after read", 1'b0);
        set_detect(1'b0);
        axi_read(EZ_ST, rd, rs);
        chk_word("flag on clear", 32'h00000001, rd);
        axi_write(EZ_EN, 32'h00000000, rs);
        set_detect(1'b1);
        chk_bit("irq masked", 1'b0);
        axi_read(EZ_ST, rd, rs);
        chk_word("flag while masked", 32'h00000001, rd);
    endtask : t_zero_run

    task automatic t_long_msg;
        axi_write(LM_EN, 32'h00000001, rs);
        axi_read(LM_EN, rd, rs);
        chk_word("long-msg enable", 32'h00000001, rd);
        send_msg(276);
        chk_bit("irq at limit", 1'b0);
        axi_read(LM_ST, rd, rs);
        chk_word("flag at limit", 32'h00000000, rd);
        send_msg(277);
        chk_bit("irq on long msg", 1'b1);
        axi_read(LM_ST, rd, rs);
        chk_word("long-msg flag", 32'h00000001, rd);
        axi_read(LM_ST, rd, rs);
        chk_word("long flag after read", 32'h00000000, rd);
        axi_write(LM_EN, 32'h00000000, rs);
        axi_read(LM_EN, rd, rs);
        chk_word("long-msg disable", 32'h00000000, rd);
    endtask : t_long_msg

    task automatic t_unmapped;
        axi_read(16'h1000, rd, rs);
        chk_word("unmapped read resp", 32'(RESP_DECERR), 32'(rs));
        axi_write(16'h1000, 32'h00000001, rs);
        chk_word("unmapped write resp", 32'(RESP_DECERR), 32'(rs));
    endtask : t_unmapped

    // Summary view: aliased enables, status kept on read, write-one clear
    task automatic t_summary;
        axi_write(SUM_EN, 32'h00000003, rs);
        axi_read(EZ_EN, rd, rs);
        chk_word("enable via summary", 32'h00000001, rd);
        axi_read(LM_EN, rd, rs);
        chk_word("long enable via summary", 32'h00000001, rd);
        set_detect(1'b0);
        chk_bit("irq via summary enable", 1'b1);
        axi_read(SUM_ST, rd, rs);
        chk_word("summary status", 32'h00000001, rd);
        axi_read(SUM_ST, rd, rs);
        chk_word("summary kept on read", 32'h00000001, rd);
        axi_write(SUM_CL, 32'h00000001, rs);
        chk_bit("irq after summary clear", 1'b0);
        axi_read(EZ_ST, rd, rs);
        chk_word("flag after summary clear", 32'h00000000, rd);
    endtask : t_summary

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_zero_run();
        t_long_msg();
        t_summary();
        t_unmapped();
        complete_run();
    end
endmodule : rxezo_irq_tb
